/* File: hdl/ptp_playout.sv */
// Receive dispatch, per-context jitter buffers and TDM formatter.
// Overview of operation
// - Only MAC-accepted packets reach classification.
// - Route packets to TDM, LAN or host.
// - TDM packets classified again by context.
// - Each context has its own jitter buffer.
// - Jitter depth programmed in 125 us frames.
// - Host queue drained by host DMA reads.
// - Play octets in sequence to configured timeslot.
// - Missing packet filled for its frame count.
// - Fill is last value or constant.
// - Late packet after fill is discarded.
// - New context awaits first packet indefinitely.
// - Formation time measured against reference clock.
// - Timestamp inserted after payload assembly completes.
// - One numeric oscillator per TDM port.
// - Outgoing packets carry timestamp and sequence.
// - Arrival stamp counted on port output clock.
// - Hardware gathers statistics, host steers oscillator.
// - Payload structured by channel, one timeslot per context.
`timescale 1ns/1ps
module ptp_playout
  import ptp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        pkt_valid,
  input  wire logic        pkt_sop,
  input  wire logic        pkt_eop,
  input  wire logic        pkt_ok,
  input  wire logic [7:0]  pkt_data,
  output logic             lan_valid,
  output logic             lan_sop,
  output logic             lan_eop,
  output logic [7:0]       lan_data,
  input  wire logic        tdm_clk,
  output logic             tdm_dout,
  output logic             tdm_fp,
  input  wire logic        ref_clk,
  input  wire logic        asm_done,
  output logic             tx_stamp_valid,
  output logic [15:0]      tx_ts,
  output logic [15:0]      tx_seq,
  output logic             rclk_out
);
  localparam int JB_N = NCTX * JB_DEPTH;

  logic              tdm_rise;
  logic              ref_rise;
  logic              nco_clk;
  logic [15:0]       nco_cycles;
  logic [31:0]       ctrl;
  logic [10:0]       ctx_cfg [NCTX];
  logic [23:0]       nco_freq;
  logic              dp_wr;
  logic [7:0]        dp_addr;
  logic [7:0]        jb_mem [JB_N];
  logic [JB_N-1:0]   vld;
  logic [8:0]        hq_mem [HQ_DEPTH];
  logic [HQ_W:0]     hq_wp;
  logic [HQ_W:0]     hq_rp;
  ptp_rx_t           rx_st;
  logic [CTX_W-1:0]  rx_ctx;
  logic [7:0]        wr_frame;
  logic [3:0]        wr_cnt;
  ptp_ctx_t          ctx_st [NCTX];
  logic [7:0]        play_frame [NCTX];
  logic [7:0]        last_oct [NCTX];
  logic [7:0]        bit_cnt;
  logic [7:0]        shreg;
  logic [15:0]       tdm_ts;
  logic [15:0]       ref_cnt;
  logic [17:0]       arr_ts;
  logic [7:0]        drop_cnt;
  logic [15:0]       undr_cnt;

  logic              acc;
  logic              hq_empty;
  logic              hq_full;
  logic              hq_pop;
  logic              hq_push;
  logic [8:0]        hq_din;
  logic [3:0]        fpp;
  logic [7:0]        fill_val;
  logic              jb_we;
  logic [CTX_W+JB_W-1:0] jb_wa;
  logic [CTX_W+JB_W-1:0] jb_ra;
  logic              hit;
  logic [CTX_W-1:0]  hc;
  logic [7:0]        octet;
  logic              rd_now;
  logic [7:0]        base;
  logic [7:0]        diff;
  logic [31:0]       rd;

  ptp_edge_sync u_tdm_sync (.hclk(hclk), .hresetn(hresetn), .din(tdm_clk), .rise(tdm_rise));
  ptp_edge_sync u_ref_sync (.hclk(hclk), .hresetn(hresetn), .din(ref_clk), .rise(ref_rise));

  ptp_port_nco u_nco (
    .hclk    (hclk),
    .hresetn (hresetn),
    .freq    (nco_freq),
    .clk_out (nco_clk),
    .cycles  (nco_cycles)
  );

  assign acc      = hsel & hready & htrans[1];
  assign hq_empty = (hq_wp == hq_rp);
  assign hq_full  = (hq_wp[HQ_W] != hq_rp[HQ_W]) && (hq_wp[HQ_W-1:0] == hq_rp[HQ_W-1:0]);
  assign hq_pop   = acc & ~hwrite & (haddr[7:0] == REG_HOSTQ) & ~hq_empty;
  assign fpp      = ctrl[CTRL_FPP_LSB +: 4];
  assign fill_val = ctrl[CTRL_FILL_LSB +: 8];

  // Register read mux, sampled in the address phase.
  always_comb begin
    rd = 32'h0000_0000;
    case (haddr[7:0])
      REG_CTRL:   rd = ctrl;
      REG_STATUS: rd = {8'h00, undr_cnt[7:0], drop_cnt,
                        ctx_st[3], ctx_st[2], ctx_st[1], ctx_st[0]};
      REG_HOSTQ:  rd = {22'h00_0000, ~hq_empty, hq_mem[hq_rp[HQ_W-1:0]]};
      REG_ARRTS:  rd = {14'h0000, arr_ts};
      REG_NCO:    rd = {8'h00, nco_freq};
      REG_TXST:   rd = {tx_seq, tx_ts};
      REG_UNDR:   rd = {16'h0000, undr_cnt};
      REG_NCOCNT: rd = {16'h0000, nco_cycles};
      default: begin
        if (haddr[7:0] >= REG_CTX0 && haddr[7:0] <= REG_CTX3 && haddr[1:0] == 2'b00) begin
          rd = {21'h00_0000, ctx_cfg[haddr[3:2]]};
        end
      end
    endcase
  end

  // AHB slave: zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      ctrl      <= CTRL_RST;
      nco_freq  <= NCO_RST;
      for (int i = 0; i < NCTX; i++) begin
        ctx_cfg[i] <= CTX_RST;
      end
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dp_wr     <= acc & hwrite;
      if (acc) begin
        dp_addr <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata <= rd;
      end
      if (dp_wr) begin
        if (dp_addr == REG_CTRL) begin
          ctrl <= hwdata;
        end
        if (dp_addr == REG_NCO) begin
          nco_freq <= hwdata[23:0];
        end
        if (dp_addr >= REG_CTX0 && dp_addr <= REG_CTX3 && dp_addr[1:0] == 2'b00) begin
          ctx_cfg[dp_addr[3:2]] <= hwdata[10:0];
        end
      end
    end
  end

  // Receive dispatch state machine.
  ptp_rx_t          next_rx_st;
  logic [CTX_W-1:0] next_rx_ctx;
  logic [7:0]       next_wr_frame;
  logic [3:0]       next_wr_cnt;
  logic [7:0]       next_drop_cnt;
  logic [17:0]      next_arr_ts;
  logic             next_lan_valid;
  logic             start_ctx;

  assign base = 8'((pkt_data * fpp));
  assign diff = base - play_frame[rx_ctx];

  always_comb begin
    next_rx_st     = rx_st;
    next_rx_ctx    = rx_ctx;
    next_wr_frame  = wr_frame;
    next_wr_cnt    = wr_cnt;
    next_drop_cnt  = drop_cnt;
    next_arr_ts    = arr_ts;
    next_lan_valid = 1'b0;
    hq_push        = 1'b0;
    hq_din         = {pkt_eop, pkt_data};
    jb_we          = 1'b0;
    jb_wa          = jb_addr(rx_ctx, wr_frame);
    start_ctx      = 1'b0;
    if (pkt_valid) begin
      case (rx_st)
        RX_IDLE: begin
          if (pkt_sop && pkt_ok) begin
            case (pkt_data)
              DST_TDM:  next_rx_st = RX_CTX;
              DST_LAN:  next_rx_st = RX_LAN;
              DST_HOST: next_rx_st = RX_HOST;
              default:  next_rx_st = RX_SKIP;
            endcase
          end
        end
        RX_CTX: begin
          next_rx_ctx = pkt_data[CTX_W-1:0];
          next_rx_st  = RX_SEQ;
        end
        RX_SEQ: begin
          next_arr_ts   = {rx_ctx, tdm_ts};
          next_wr_frame = base;
          next_wr_cnt   = 4'h0;
          next_rx_st    = RX_TDM;
          if (ctx_st[rx_ctx] == CTX_AWAIT) begin
            start_ctx = 1'b1;
          end else if (ctx_st[rx_ctx] == CTX_CLOSED) begin
            next_rx_st = RX_SKIP;
          end else if (diff == 8'h00 || diff >= JB_SPAN) begin
            next_drop_cnt = drop_cnt + 8'h01;
            next_rx_st    = RX_SKIP;
          end
        end
        RX_TDM: begin
          if (wr_cnt < fpp) begin
            jb_we         = 1'b1;
            next_wr_frame = wr_frame + 8'h01;
            next_wr_cnt   = wr_cnt + 4'h1;
          end
        end
        RX_LAN:  next_lan_valid = 1'b1;
        RX_HOST: hq_push = ~hq_full;
        default: next_rx_st = rx_st;
      endcase
      if (pkt_eop) begin
        next_rx_st = RX_IDLE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st     <= RX_IDLE;
      rx_ctx    <= '0;
      wr_frame  <= 8'h00;
      wr_cnt    <= 4'h0;
      drop_cnt  <= 8'h00;
      arr_ts    <= 18'h0_0000;
      lan_valid <= 1'b0;
      lan_sop   <= 1'b0;
      lan_eop   <= 1'b0;
      lan_data  <= 8'h00;
    end else begin
      rx_st     <= next_rx_st;
      rx_ctx    <= next_rx_ctx;
      wr_frame  <= next_wr_frame;
      wr_cnt    <= next_wr_cnt;
      drop_cnt  <= next_drop_cnt;
      arr_ts    <= next_arr_ts;
      lan_valid <= next_lan_valid;
      lan_sop   <= next_lan_valid & (rx_st == RX_IDLE);
      lan_eop   <= next_lan_valid & pkt_eop;
      lan_data  <= pkt_data;
    end
  end

  // The class octet itself goes to neither the host queue nor LAN; both start with the next byte.
  always_ff @(posedge hclk) begin
    if (hq_push) begin
      hq_mem[hq_wp[HQ_W-1:0]] <= hq_din;
    end
    if (jb_we) begin
      jb_mem[jb_wa] <= pkt_data;
    end
  end

  // Formatter: pick the context owning the current slot.
  always_comb begin
    hit = 1'b0;
    hc  = '0;
    for (int i = 0; i < NCTX; i++) begin
      if (ctx_st[i] == CTX_RUN && ctx_cfg[i][CTX_SLOT_LSB +: 5] == bit_cnt[7:3]) begin
        hit = 1'b1;
        hc  = CTX_W'(i);
      end
    end
    jb_ra  = jb_addr(hc, play_frame[hc]);
    rd_now = tdm_rise & (bit_cnt[2:0] == SLOT_FIRST_BIT) & hit;
    if (hit && vld[jb_ra]) begin
      octet = jb_mem[jb_ra];
    end else if (hit && ctrl[CTRL_FILL_LAST_BIT]) begin
      octet = last_oct[hc];
    end else begin
      octet = fill_val;
    end
  end

  // Context state, playout frames and valid flags.
  ptp_ctx_t        next_ctx_st [NCTX];
  logic [7:0]      next_play [NCTX];
  logic [7:0]      next_last [NCTX];
  logic [JB_N-1:0] next_vld;
  logic [15:0]     next_undr;
  logic [7:0]      next_bit_cnt;
  logic [7:0]      next_shreg;
  logic            next_dout;

  always_comb begin
    next_vld     = vld;
    next_undr    = undr_cnt;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_dout    = tdm_dout;
    for (int i = 0; i < NCTX; i++) begin
      next_ctx_st[i] = ctx_st[i];
      next_play[i]   = play_frame[i];
      next_last[i]   = last_oct[i];
      if (!ctx_cfg[i][CTX_OPEN_BIT]) begin
        next_ctx_st[i] = CTX_CLOSED;
      end else if (ctx_st[i] == CTX_CLOSED) begin
        next_ctx_st[i] = CTX_AWAIT;
      end
      if (tdm_rise && bit_cnt == FRAME_LAST_BIT && ctx_st[i] == CTX_RUN) begin
        next_play[i] = play_frame[i] + 8'h01;
      end
    end
    if (start_ctx) begin
      next_ctx_st[rx_ctx] = CTX_RUN;
      next_play[rx_ctx]   = base - {3'b000, ctx_cfg[rx_ctx][CTX_DEPTH_LSB +: 5]};
    end
    if (tdm_rise) begin
      next_bit_cnt = bit_cnt + 8'h01;
      if (bit_cnt[2:0] == SLOT_FIRST_BIT) begin
        next_dout  = octet[7];
        next_shreg = {octet[6:0], 1'b0};
      end else begin
        next_dout  = shreg[7];
        next_shreg = {shreg[6:0], 1'b0};
      end
    end
    if (rd_now) begin
      next_vld[jb_ra] = 1'b0;
      next_last[hc]   = octet;
      if (!vld[jb_ra]) begin
        next_undr = undr_cnt + 16'h0001;
      end
    end
    // A write to the entry being read in the same cycle wins over the read's clear, leaving it valid.
    if (jb_we) begin
      next_vld[jb_wa] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vld      <= '0;
      undr_cnt <= 16'h0000;
      bit_cnt  <= 8'h00;
      shreg    <= 8'h00;
      tdm_dout <= 1'b1;
      tdm_fp   <= 1'b0;
      tdm_ts   <= 16'h0000;
      hq_wp    <= '0;
      hq_rp    <= '0;
      for (int i = 0; i < NCTX; i++) begin
        ctx_st[i]     <= CTX_CLOSED;
        play_frame[i] <= 8'h00;
        last_oct[i]   <= 8'h00;
      end
    end else begin
      vld      <= next_vld;
      undr_cnt <= next_undr;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      tdm_dout <= next_dout;
      tdm_fp   <= tdm_rise ? (bit_cnt == 8'h00) : tdm_fp;
      tdm_ts   <= tdm_rise ? tdm_ts + 16'h0001 : tdm_ts;
      hq_wp    <= hq_push ? hq_wp + 1'b1 : hq_wp;
      hq_rp    <= hq_pop ? hq_rp + 1'b1 : hq_rp;
      for (int i = 0; i < NCTX; i++) begin
        ctx_st[i]     <= next_ctx_st[i];
        play_frame[i] <= next_play[i];
        last_oct[i]   <= next_last[i];
      end
    end
  end

  // Transmit stamping against the common reference clock.
  logic [15:0] next_ref_cnt;

  always_comb begin
    next_ref_cnt = ref_rise ? ref_cnt + 16'h0001 : ref_cnt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt        <= 16'h0000;
      tx_stamp_valid <= 1'b0;
      tx_ts          <= 16'h0000;
      tx_seq         <= 16'h0000;
      rclk_out       <= 1'b0;
    end else begin
      ref_cnt        <= next_ref_cnt;
      tx_stamp_valid <= asm_done;
      rclk_out       <= nco_clk;
      if (asm_done) begin
        tx_ts  <= ref_cnt;
        tx_seq <= tx_seq + 16'h0001;
      end
    end
  end
endmodule // ptp_playout

/* File: hdl/ptp_pkg.sv */
// Shared constants and types for the packet to TDM playout block.
package ptp_pkg;

  // Sizes of the context table, jitter buffers and host queue.
  localparam int NCTX     = 4;
  localparam int CTX_W    = 2;
  localparam int JB_DEPTH = 32;
  localparam int JB_W     = 5;
  localparam int HQ_DEPTH = 16;
  localparam int HQ_W     = 4;

  // One TDM frame lasts 125 us and carries 32 timeslots of 8 bits.
  localparam int FRAME_TIME_US = 125;
  localparam logic [7:0] FRAME_LAST_BIT = 8'hFF;
  localparam logic [2:0] SLOT_FIRST_BIT = 3'h0;

  // Jitter window: a packet must start 1 to 31 frames ahead of playout.
  localparam logic [7:0] JB_SPAN = 8'h20;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_CTX0    = 8'h10;
  localparam logic [7:0] REG_CTX3    = 8'h1C;
  localparam logic [7:0] REG_HOSTQ   = 8'h20;
  localparam logic [7:0] REG_ARRTS   = 8'h24;
  localparam logic [7:0] REG_NCO     = 8'h28;
  localparam logic [7:0] REG_TXST    = 8'h2C;
  localparam logic [7:0] REG_UNDR    = 8'h30;
  localparam logic [7:0] REG_NCOCNT  = 8'h34;

  // Field positions and reset values.
  localparam int CTRL_FILL_LAST_BIT = 0;
  localparam int CTRL_FILL_LSB      = 8;
  localparam int CTRL_FPP_LSB       = 16;
  localparam logic [31:0] CTRL_RST  = 32'h0001_FF00;
  localparam int CTX_OPEN_BIT       = 0;
  localparam int CTX_SLOT_LSB       = 1;
  localparam int CTX_DEPTH_LSB      = 6;
  localparam logic [10:0] CTX_RST   = 11'h000;
  localparam logic [23:0] NCO_RST   = 24'h00_0000;

  // Destination codes carried in the first octet of each packet.
  localparam logic [7:0] DST_TDM  = 8'h00;
  localparam logic [7:0] DST_LAN  = 8'h01;
  localparam logic [7:0] DST_HOST = 8'h02;

  typedef enum logic [1:0] {CTX_CLOSED, CTX_AWAIT, CTX_RUN} ptp_ctx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_CTX, RX_SEQ, RX_TDM, RX_LAN, RX_HOST,
                            RX_SKIP} ptp_rx_t;

  // Flat index of one frame entry of one context's jitter buffer.
  function automatic logic [CTX_W+JB_W-1:0] jb_addr(input logic [CTX_W-1:0] ctx,
                                                    input logic [7:0] frame);
    jb_addr = {ctx, frame[JB_W-1:0]};
  endfunction

endpackage

/* File: hdl/ptp_edge_sync.sv */
// Two-flop synchroniser with rising edge detector for an outside clock.
`timescale 1ns/1ps
module ptp_edge_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic din,
  output logic      rise
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign rise = s2 & ~s3;
endmodule // ptp_edge_sync

/* File: hdl/ptp_port_nco.sv */
// Per-port numeric oscillator steered by host software.
`timescale 1ns/1ps
module ptp_port_nco (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [23:0] freq,
  output logic             clk_out,
  output logic [15:0]      cycles
);
  logic [23:0] acc;
  logic [23:0] next_acc;
  logic [15:0] next_cycles;

  always_comb begin
    next_acc    = acc + freq;
    next_cycles = cycles;
    // Count output periods so software can compare them with arrival stamps.
    if (next_acc[23] && !acc[23]) begin
      next_cycles = cycles + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc     <= 24'h00_0000;
      clk_out <= 1'b0;
      cycles  <= 16'h0000;
    end else begin
      acc     <= next_acc;
      clk_out <= acc[23];
      cycles  <= next_cycles;
    end
  end
endmodule // ptp_port_nco

/* File: tb/ptp_playout_sva.sv */
// Port-level assertions for the packet to TDM playout block.
`timescale 1ns/1ps
module ptp_playout_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        pkt_valid,
  input wire logic        pkt_eop,
  input wire logic        lan_valid,
  input wire logic        lan_eop,
  input wire logic        asm_done,
  input wire logic        tx_stamp_valid,
  input wire logic [15:0] tx_seq,
  input wire logic        tdm_fp
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence fp_start;
    $rose(tdm_fp);
  endsequence
  // A bit period is eight system cycles, so the pulse must last at least four.
  sequence fp_body;
    tdm_fp [*4] ##[1:12] !tdm_fp;
  endsequence

  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("Bus response is not OKAY.");
  ready_on_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("Slave inserted a wait state.");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("Read data changed without a read.");
  lan_in_a: assert property (lan_valid |-> $past(pkt_valid))
    else $error("LAN byte without an input byte.");
  lan_eop_a: assert property (lan_eop |-> lan_valid && $past(pkt_eop))
    else $error("LAN end of packet out of place.");
  stamp_pulse_a: assert property (tx_stamp_valid == $past(asm_done))
    else $error("Stamp pulse not one cycle after assembly.");
  seq_step_a: assert property (tx_stamp_valid |-> tx_seq == $past(tx_seq) + 16'h0001)
    else $error("Sequence did not step by one.");
  seq_hold_a: assert property (!tx_stamp_valid |-> $stable(tx_seq))
    else $error("Sequence moved without a stamp.");
  fp_width_a: assert property (fp_start |-> fp_body)
    else $error("Frame pulse width wrong.");
endmodule // ptp_playout_sva

bind ptp_playout ptp_playout_sva i_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pkt_valid(pkt_valid), .pkt_eop(pkt_eop), .lan_valid(lan_valid), .lan_eop(lan_eop),
  .asm_done(asm_done), .tx_stamp_valid(tx_stamp_valid), .tx_seq(tx_seq), .tdm_fp(tdm_fp)
);

/* File: tb/ptp_mac_model.sv */
// Packet source standing in for the receiving network MAC.
`timescale 1ns/1ps
module ptp_mac_model (
  input  wire logic  hclk,
  output logic       pkt_valid,
  output logic       pkt_sop,
  output logic       pkt_eop,
  output logic       pkt_ok,
  output logic [7:0] pkt_data
);
  initial begin
    pkt_valid = 1'b0;
    pkt_sop   = 1'b0;
    pkt_eop   = 1'b0;
    pkt_ok    = 1'b0;
    pkt_data  = 8'h00;
  end

  task automatic send(input logic [7:0] b[$], input logic ok);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge hclk);
      pkt_valid <= 1'b1;
      pkt_sop   <= (i == 0);
      pkt_eop   <= (i == b.size() - 1);
      pkt_ok    <= ok;
      pkt_data  <= b[i];
    end
    @(posedge hclk);
    pkt_valid <= 1'b0;
    pkt_eop   <= 1'b0;
    // Idle lines flip so that a block reading them outside a byte is caught.
    pkt_ok    <= ~ok;
    pkt_data  <= ~b[b.size() - 1];
  endtask
endmodule // ptp_mac_model

/* File: tb/ptp_playout_tb.sv */
// Self-checking bench for the packet to TDM playout block.
`timescale 1ns/1ps
module ptp_playout_tb
  import ptp_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, tdm_clk = 1'b0, ref_clk = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, asm_done = 1'b0, rph = 1'b0, go = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv, r;
  logic        hreadyout, lan_eop, tdm_dout, tdm_fp;
  logic        pkt_valid, pkt_sop, pkt_eop, pkt_ok;
  logic [7:0]  pkt_data, lan_data, s, sh = 8'h00;
  logic [7:0]  p[4];
  logic [63:0] rq[$];
  logic [7:0]  lq[$], tq[$];
  int          n_tests = 0, fail_count = 0, tn = 0, bc = 0;
  integer      seed = 32'h379F;
  wire         hready = hreadyout;

  initial forever #50 hclk = ~hclk;
  initial begin
    #37;
    forever #400 tdm_clk = ~tdm_clk;
  end
  initial forever #400 ref_clk = ~ref_clk;

  ptp_mac_model i_mac (.hclk, .pkt_valid, .pkt_sop, .pkt_eop, .pkt_ok, .pkt_data);
  ptp_playout i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout, .hresp(), .hrdata, .pkt_valid, .pkt_sop, .pkt_eop, .pkt_ok, .pkt_data,
    .lan_valid(), .lan_sop(), .lan_eop, .lan_data, .tdm_clk, .tdm_dout, .tdm_fp,
    .ref_clk, .asm_done, .tx_stamp_valid(), .tx_ts(), .tx_seq(), .rclk_out()
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // For reads d is the expected value under mask m; a zero mask skips the compare.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) rq.push_back({m, d & m});
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    if (rph && hready === 1'b1) begin
      if (rq[0][63:32] != 32'h0) chk(hrdata & rq[0][63:32], rq[0][31:0]);
      void'(rq.pop_front());
    end
    rph <= hsel && hready && htrans[1] && !hwrite;
  end

  always @(posedge hclk) begin
    if (lan_eop === 1'b1) begin
      if (lq.size() == 0) chk({24'h0, lan_data}, 32'h1FF);
      else chk({24'h0, lan_data}, {24'h0, lq.pop_front()});
    end
  end

  // Slot 1 is bits 8 to 15; leading zero fill before the first payload is skipped.
  always @(posedge tdm_clk) begin
    sh = {sh[6:0], tdm_dout};
    bc = (tdm_fp === 1'b1) ? 0 : bc + 1;
    if (bc == 15 && tq.size() != 0 && (go || sh != 8'h00)) begin
      go = 1'b1;
      tn++;
      chk({24'h0, sh}, {24'h0, tq.pop_front()});
    end
  end

  initial begin
    repeat (60000) @(posedge hclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, REG_CTRL, CTRL_RST, 32'hFFFFFFFF);
    ahb(1'b0, REG_CTX0, 32'h0, 32'hFFFFFFFF);
    ahb(1'b0, REG_STATUS, 32'h0, 32'hFFFFFFFF);
    ahb(1'b0, 8'h3C, 32'h0, 32'hFFFFFFFF);
    r = $random(seed) & 32'h00FFFFFF;
    ahb(1'b1, REG_NCO, r, 32'h0);
    ahb(1'b0, REG_NCO, r, 32'h00FFFFFF);
    @(posedge hclk) asm_done <= 1'b1;
    @(posedge hclk) asm_done <= 1'b0;
    ahb(1'b0, REG_TXST, 32'h00010000, 32'hFFFF0000);
    r = $random(seed);
    lq.push_back(r[15:8]);
    i_mac.send('{DST_LAN, r[7:0], r[15:8]}, 1'b1);
    i_mac.send('{DST_LAN, r[23:16], r[31:24]}, 1'b0);
    i_mac.send('{DST_HOST, r[7:0]}, 1'b1);
    repeat (4) @(posedge hclk);
    rdv = 32'h0;
    for (int i = 0; i < 6 && rdv[8] !== 1'b1; i++) ahb(1'b0, REG_HOSTQ, 32'h0, 32'h0);
    chk({22'h0, rdv[9:0]}, {22'h0, 2'b11, r[7:0]});
    ahb(1'b0, REG_HOSTQ, 32'h0, 32'h00000200);
    ahb(1'b1, REG_CTRL, 32'h00010000, 32'h0);
    ahb(1'b1, REG_CTX0, 32'h00000103, 32'h0);
    ahb(1'b0, REG_STATUS, 32'h1, 32'h3);
    repeat (3000) @(posedge hclk);
    ahb(1'b0, REG_STATUS, 32'h1, 32'h3);
    i_mac.send('{DST_TDM, 8'h01, 8'h10, 8'h55}, 1'b1);
    s = r[23:16];
    for (int i = 0; i < 4; i++) p[i] = 8'($random(seed)) | 8'h01;
    tq = '{p[0], p[1], 8'h00, p[3], p[3]};
    i_mac.send('{DST_TDM, 8'h00, s, p[0]}, 1'b1);
    i_mac.send('{DST_TDM, 8'h00, s + 8'h01, p[1]}, 1'b1);
    i_mac.send('{DST_TDM, 8'h00, s + 8'h03, p[3]}, 1'b1);
    ahb(1'b0, REG_STATUS, 32'h2, 32'h3);
    while (tn < 3) @(posedge hclk);
    ahb(1'b1, REG_CTRL, 32'h00010001, 32'h0);
    i_mac.send('{DST_TDM, 8'h00, s + 8'h02, p[2]}, 1'b1);
    while (tn < 5) @(posedge hclk);
    ahb(1'b0, REG_STATUS, 32'h00000100, 32'h0000FF00);
    ahb(1'b0, REG_ARRTS, 32'h0, 32'h00030000);
    chk(32'(lq.size()), 32'h0);
    print_verdict();
  end
endmodule // ptp_playout_tb
